// File: verification/crpm_master_model.sv
/* Network master model offering receive frames to the block.
   Its send task is called from the bench. */
`timescale 1ns/1ps
module crpm_master_model
    import crpm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output crpm_frame_t rx_frame_o
);
    initial
    begin
        rx_valid_o = 1'b0;
        rx_frame_o = '0;
    end
    // Released lines show the inverse frame, never a stale copy.
    task automatic send(input logic [10:0] id, input logic [3:0] dlc,
        input logic [63:0] d, input int gap);
        crpm_frame_t f;
        f = '{rpdo4_frame_identifier: id, dlc: dlc, data: d};
        repeat (gap) @(posedge core_clk_i);
        @(posedge core_clk_i);
        rx_valid_o <= 1'b1;
        rx_frame_o <= f;
        do @(posedge core_clk_i); while (rx_ready_i !== 1'b1);
        rx_valid_o <= 1'b0;
        rx_frame_o <= ~f;
    endtask
endmodule // crpm_master_model

// File: verification/crpm_rx_map_props.sv
/* Port assertions for the receive mapping block.
   Bound into crpm_rx_map; sees only its ports. */
`timescale 1ns/1ps
module crpm_rx_map_props
    import crpm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire crpm_nmt_t nmt_state_i,
    input wire logic od_req_i,
    input wire logic od_wr_i,
    input wire logic [15:0] od_index_i,
    input wire logic [7:0] od_sub_i,
    input wire logic od_ready_o,
    input wire logic od_ack_o,
    input wire logic od_err_o,
    input wire logic [31:0] od_rdata_o,
    input wire logic ctrl_word_stb_o,
    input wire logic op_mode_stb_o,
    input wire logic target_velocity_stb_o,
    input wire logic velocity_profile_setpoint_mode_o
);
    logic take;
    logic known;
    logic any_stb;
    logic [4:0] idle_q;
    logic [4:0] idle_d;
    assign take = od_req_i && od_ready_o;
    assign known = od_index_i == OD_IDX_R4_COMM || od_index_i == OD_IDX_MAP1
        || od_index_i == OD_IDX_MAP2;
    assign any_stb = ctrl_word_stb_o || op_mode_stb_o || target_velocity_stb_o;
    // The longest walk is 18 cycles, so 20 idle cycles leave no commit.
    always_comb
    begin
        idle_d = idle_q;
        if (nmt_state_i == NMT_OPER)
            idle_d = 5'h00;
        else if (idle_q != 5'h1F)
            idle_d = idle_q + 5'h01;
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            idle_q <= 5'h00;
        else
            idle_q <= idle_d;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_ack_t2; take |-> ##2 od_ack_o; endproperty
    a_ack_t2: assert property (p_ack_t2) else $error("ack late");
    property p_ack_one; od_ack_o |=> !od_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack long");
    property p_ack_cause; od_ack_o |-> $past(take, 2); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("no take");
    property p_err_wr;
        take && od_wr_i && nmt_state_i != NMT_PREOP |-> ##2 od_err_o;
    endproperty
    a_err_wr: assert property (p_err_wr) else $error("write taken");
    property p_err_idx;
        take && !known |-> ##2 od_ack_o && od_err_o;
    endproperty
    a_err_idx: assert property (p_err_idx) else $error("bad index");
    property p_cnt_ro;
        take && !od_wr_i && od_index_i == OD_IDX_R4_COMM && od_sub_i == 8'h00
        |-> ##2 od_rdata_o == 32'h00000002 && !od_err_o;
    endproperty
    a_cnt_ro: assert property (p_cnt_ro) else $error("entry count");
    property p_idle; idle_q >= 5'h14 |-> !any_stb; endproperty
    a_idle: assert property (p_idle) else $error("update idle");
    property p_vel_cw; target_velocity_stb_o |-> ctrl_word_stb_o; endproperty
    a_vel_cw: assert property (p_vel_cw) else $error("vel no cw");
    property p_pv;
        target_velocity_stb_o |-> ##[0:1] velocity_profile_setpoint_mode_o;
    endproperty
    a_pv: assert property (p_pv) else $error("mode flag");
    c_write: cover property (take && od_wr_i);
    c_vel: cover property (target_velocity_stb_o);
    c_op: cover property (op_mode_stb_o);
endmodule // crpm_rx_map_props

bind crpm_rx_map crpm_rx_map_props u_props (.core_clk_i, .reset_n_i,
    .nmt_state_i, .od_req_i, .od_wr_i, .od_index_i, .od_sub_i, .od_ready_o,
    .od_ack_o, .od_err_o, .od_rdata_o, .ctrl_word_stb_o, .op_mode_stb_o,
    .target_velocity_stb_o, .velocity_profile_setpoint_mode_o);

// File: verification/crpm_rx_map_tb.sv
/* Self-checking bench for crpm_rx_map and the master model.
   Assumes NODE_ID 1 and the documented defaults after reset. */
`timescale 1ns/1ps
module crpm_rx_map_tb
    import crpm_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    crpm_nmt_t nmt = NMT_INIT;
    logic sync = 1'b0;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [15:0] idx = 16'h0000;
    logic [7:0] sub = 8'h00;
    logic [31:0] wd = 32'h00000000;
    logic rx_valid, rx_ready, od_ready, od_ack, od_err;
    logic cw_stb, op_stb, vel_stb, pv;
    crpm_frame_t rx_frame;
    logic [31:0] od_rdata, vel;
    logic [15:0] cw;
    logic [7:0] op;
    logic [7:0] t;
    int n_cw = 0, n_op = 0, n_vel = 0, cyc = 0, error_cnt = 0, checked = 0;
    logic [55:0] tbl [9] = '{56'h1403_00_00000002, 56'h1403_01_00000501,
        56'h1403_02_000000FF, 56'h1600_00_00000001, 56'h1600_01_60400010,
        56'h1600_08_00000000, 56'h1601_00_00000002, 56'h1601_01_60400010,
        56'h1601_02_60600008};
    logic [7:0] tt [3] = '{8'hFE, 8'h02, 8'hF0};
    crpm_rx_map #(.NODE_ID(7'h01)) dut (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .nmt_state_i(nmt), .sync_i(sync),
        .rx_valid_i(rx_valid), .rx_frame_i(rx_frame), .rx_ready_o(rx_ready),
        .od_req_i(req), .od_wr_i(wr), .od_index_i(idx), .od_sub_i(sub),
        .od_wdata_i(wd), .od_ready_o(od_ready), .od_ack_o(od_ack),
        .od_err_o(od_err), .od_rdata_o(od_rdata), .ctrl_word_o(cw),
        .ctrl_word_stb_o(cw_stb), .op_mode_o(op), .op_mode_stb_o(op_stb),
        .target_velocity_o(vel), .target_velocity_stb_o(vel_stb),
        .velocity_profile_setpoint_mode_o(pv));
    crpm_master_model mst (.core_clk_i(core_clk_i), .rx_ready_i(rx_ready),
        .rx_valid_o(rx_valid), .rx_frame_o(rx_frame));
    always #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cw_stb === 1'b1)
            n_cw++;
        if (op_stb === 1'b1)
            n_op++;
        if (vel_stb === 1'b1)
            n_vel++;
        if (cyc == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, input logic xe, input logic [31:0] xr);
        int n;
        @(posedge core_clk_i);
        req <= 1'b1;
        wr <= w;
        idx <= i;
        sub <= s;
        wd <= d;
        do @(posedge core_clk_i); while (od_ready !== 1'b1);
        req <= 1'b0;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (od_ack !== 1'b1 && n < 4);
        check("od_ack", 32'(od_ack), 32'h00000001);
        check("od_err", 32'(od_err), 32'(xe));
        if (!w && !xe)
            check("od_rdata", od_rdata, xr);
    endtask
    task automatic cnt(input int c, o, v);
        repeat (25) @(posedge core_clk_i);
        check("n_cw", 32'(n_cw), 32'(c));
        check("n_op", 32'(n_op), 32'(o));
        check("n_vel", 32'(n_vel), 32'(v));
        n_cw = 0;
        n_op = 0;
        n_vel = 0;
    endtask
    task automatic pulse();
        @(posedge core_clk_i);
        sync <= 1'b1;
        @(posedge core_clk_i);
        sync <= 1'b0;
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        for (int k = 0; k < 9; k++)
            od(1'b0, tbl[k][55:40], tbl[k][39:32], '0, 1'b0,
                tbl[k][31:0]);
        od(1'b0, 16'h1602, 8'h00, '0, 1'b1, '0);
        od(1'b1, 16'h1600, 8'h00, 32'h2, 1'b1, '0);
        od(1'b0, 16'h1600, 8'h00, '0, 1'b0, 32'h1);
        nmt <= NMT_PREOP;
        od(1'b1, 16'h1403, 8'h00, 32'h3, 1'b1, '0);
        od(1'b1, 16'h1600, 8'h00, 32'h9, 1'b1, '0);
        mst.send(11'h201, 4'h2, 64'h1234, 0);
        cnt(0, 0, 0);
        $display("test config done");
        nmt <= NMT_OPER;
        mst.send(11'h301, 4'h3, 64'h040006, 3);
        cnt(1, 1, 0);
        check("cw", 32'(cw), 32'h00000006);
        check("op", 32'(op), 32'h00000004);
        mst.send(11'h201, 4'h1, 64'h55, 0);
        cnt(0, 0, 0);
        mst.send(11'h201, 4'h2, 64'h1234, 1);
        cnt(1, 0, 0);
        check("cw", 32'(cw), 32'h00001234);
        mst.send(11'h501, 4'h6, 64'h12345678000F, 0);
        cnt(1, 0, 1);
        check("vel", vel, 32'h12345678);
        check("cw", 32'(cw), 32'h0000000F);
        check("pv", 32'(pv), 32'h00000001);
        mst.send(11'h501, 4'h5, 64'h1, 0);
        cnt(0, 0, 0);
        mst.send(11'h301, 4'h3, 64'h040006, 0);
        cnt(1, 1, 0);
        check("pv", 32'(pv), 32'h00000000);
        $display("test frames done");
        nmt <= NMT_PREOP;
        od(1'b1, 16'h1600, 8'h00, 32'h2, 1'b0, '0);
        od(1'b1, 16'h1600, 8'h01, 32'h00000008, 1'b0, '0);
        od(1'b1, 16'h1600, 8'h02, 32'h60400010, 1'b0, '0);
        nmt <= NMT_OPER;
        mst.send(11'h201, 4'h3, 64'hABCD11, 2);
        cnt(1, 0, 0);
        check("cw", 32'(cw), 32'h0000ABCD);
        $display("test remap done");
        for (int k = 0; k < 3; k++)
        begin
            t = tt[k];
            nmt <= NMT_PREOP;
            od(1'b1, 16'h1403, 8'h02, 32'(t), 1'b0, '0);
            nmt <= NMT_OPER;
            mst.send(11'h501, 4'h6, {40'h0, t, 16'h000F}, 0);
            if (t <= 8'hF0)
            begin
                repeat (int'(t) - 1) pulse();
                cnt(0, 0, 0);
                pulse();
            end
            cnt(1, 0, 1);
            check("vel", vel, 32'(t));
        end
        nmt <= NMT_PREOP;
        od(1'b1, 16'h1403, 8'h01, 32'h80000501, 1'b0, '0);
        nmt <= NMT_OPER;
        mst.send(11'h501, 4'h6, 64'h1, 0);
        cnt(0, 0, 0);
        $display("test types done");
        give_verdict();
    end
endmodule // crpm_rx_map_tb

// File: verilog/crpm_desc_mem.sv
/*
 * Sixteen-word store for the mapping descriptors of both tables, one
 * write port and one read port with registered read data. Assumes the
 * caller never needs the written word on the read port in the same cycle.
 */
`timescale 1ns/1ps
module crpm_desc_mem
    import crpm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [3:0] rd_addr_i,
    output logic [31:0] rd_data_o
);

    logic [31:0] mem_q [16];

    // Flops rather than a RAM macro so that the default mapping exists
    // straight out of reset.
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < 16; i++)
                mem_q[i] <= crpm_desc_default(4'(i));
            rd_data_o <= 32'h00000000;
        end
        else
        begin
            if (wr_en_i)
                mem_q[wr_addr_i] <= wr_data_i;
            rd_data_o <= mem_q[rd_addr_i];
        end
    end

endmodule // crpm_desc_mem

// File: verilog/crpm_pkg.sv
/*
 * Shared constants, types and decode functions for the receive process
 * data mapping block. Assumes one 200 MHz clock and a CAN controller that
 * hands over complete, already checked frames on the same clock.
 */
package crpm_pkg;

    localparam logic [15:0] OD_IDX_R4_COMM = 16'h1403;
    localparam logic [15:0] OD_IDX_MAP1 = 16'h1600;
    localparam logic [15:0] OD_IDX_MAP2 = 16'h1601;
    localparam logic [7:0] OD_SUB_COUNT = 8'h00;
    localparam logic [7:0] OD_SUB_COB = 8'h01;
    localparam logic [7:0] OD_SUB_TT = 8'h02;
    localparam logic [7:0] OD_SUB_DESC_LAST = 8'h08;

    localparam logic [7:0] R4_COMM_ENTRIES = 8'h02;
    localparam logic [7:0] MAP_MAX = 8'h08;
    localparam logic [7:0] TT_SYNC_MIN = 8'h01;
    localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
    localparam logic [7:0] TT_ASYNC_A = 8'hFE;
    localparam logic [7:0] TT_ASYNC_B = 8'hFF;
    localparam logic [7:0] TT_RST = 8'hFF;
    localparam int COB_INVALID_BIT = 31;

    localparam logic [10:0] RPDO1_COB_BASE = 11'h200;
    localparam logic [10:0] RPDO2_COB_BASE = 11'h300;
    localparam logic [10:0] RPDO4_COB_BASE = 11'h500;

    localparam logic [15:0] OBJ_CTRL_WORD = 16'h6040;
    localparam logic [15:0] OBJ_OP_MODE = 16'h6060;
    localparam logic [7:0] OBJ_SUB = 8'h00;
    localparam logic [7:0] LEN_CTRL_WORD = 8'h10;
    localparam logic [7:0] LEN_OP_MODE = 8'h08;
    localparam logic [31:0] MAP_CTRL_WORD = 32'h60400010;
    localparam logic [31:0] MAP_OP_MODE = 32'h60600008;
    localparam logic [7:0] MAP1_CNT_RST = 8'h01;
    localparam logic [7:0] MAP2_CNT_RST = 8'h02;
    localparam logic [3:0] MEM_MAP2_BASE = 4'h8;

    localparam logic [10:0] FRAME_BITS = 11'h040;
    localparam logic [3:0] R4_MIN_BYTES = 4'h6;
    localparam int R4_CW_LSB = 0;
    localparam int R4_VEL_LSB = 16;

    typedef enum logic [1:0] {
        NMT_INIT = 2'h0,
        NMT_PREOP = 2'h1,
        NMT_OPER = 2'h3,
        NMT_STOPPED = 2'h2
    } crpm_nmt_t;

    typedef struct packed {
        logic [10:0] rpdo4_frame_identifier;
        logic [3:0] dlc;
        logic [63:0] data;
    } crpm_frame_t;

    // Layout of one mapping descriptor: index, sub-index, length in bits.
    typedef struct packed {
        logic [15:0] index;
        logic [7:0] sub;
        logic [7:0] len;
    } crpm_desc_t;

    typedef enum logic [2:0] {
        OD_NONE = 3'h0,
        OD_R4_CNT = 3'h1,
        OD_R4_COB = 3'h2,
        OD_R4_TT = 3'h3,
        OD_MAP_CNT = 3'h4,
        OD_MAP_DESC = 3'h5
    } crpm_od_kind_t;

    typedef struct packed {
        crpm_od_kind_t kind;
        logic tbl;
        logic [2:0] slot;
    } crpm_od_sel_t;

    function automatic crpm_od_sel_t crpm_od_decode(
        input logic [15:0] index,
        input logic [7:0] sub
    );
        crpm_od_sel_t s;
        s = '{kind: OD_NONE, tbl: 1'b0, slot: 3'h0};
        if (index == OD_IDX_R4_COMM)
        begin
            if (sub == OD_SUB_COUNT)
                s.kind = OD_R4_CNT;
            else if (sub == OD_SUB_COB)
                s.kind = OD_R4_COB;
            else if (sub == OD_SUB_TT)
                s.kind = OD_R4_TT;
        end
        else if (index == OD_IDX_MAP1 || index == OD_IDX_MAP2)
        begin
            s.tbl = (index == OD_IDX_MAP2);
            if (sub == OD_SUB_COUNT)
                s.kind = OD_MAP_CNT;
            else if (sub <= OD_SUB_DESC_LAST)
            begin
                s.kind = OD_MAP_DESC;
                s.slot = 3'(sub - 8'h01);
            end
        end
        return s;
    endfunction

    function automatic logic [31:0] crpm_desc_default(input logic [3:0] a);
        logic [31:0] v;
        v = 32'h00000000;
        if (a == 4'h0 || a == MEM_MAP2_BASE)
            v = MAP_CTRL_WORD;
        else if (a == MEM_MAP2_BASE + 4'h1)
            v = MAP_OP_MODE;
        return v;
    endfunction

endpackage

// File: verilog/crpm_rx_map.sv
/*
 * Receive process data mapping: object dictionary entries for the fourth
 * receive PDO and the first two mapping tables, the mapping walk that
 * scatters frame payload into drive objects, and the velocity PDO path.
 * Assumes frames and object dictionary requests come from logic on the
 * same clock, so no input is synchronised.
 */
`timescale 1ns/1ps
module crpm_rx_map
    import crpm_pkg::*;
#(
    parameter logic [6:0] NODE_ID = 7'h01
)
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire crpm_nmt_t nmt_state_i,
    input wire logic sync_i,
    input wire logic rx_valid_i,
    input wire crpm_frame_t rx_frame_i,
    output logic rx_ready_o,
    input wire logic od_req_i,
    input wire logic od_wr_i,
    input wire logic [15:0] od_index_i,
    input wire logic [7:0] od_sub_i,
    input wire logic [31:0] od_wdata_i,
    output logic od_ready_o,
    output logic od_ack_o,
    output logic od_err_o,
    output logic [31:0] od_rdata_o,
    output logic [15:0] ctrl_word_o,
    output logic ctrl_word_stb_o,
    output logic [7:0] op_mode_o,
    output logic op_mode_stb_o,
    output logic [31:0] target_velocity_o,
    output logic target_velocity_stb_o,
    output logic velocity_profile_setpoint_mode_o
);

    typedef enum logic [1:0] {
        ENG_IDLE = 2'h0,
        ENG_READ = 2'h1,
        ENG_EVAL = 2'h3,
        ENG_DONE = 2'h2
    } crpm_eng_t;

    localparam logic [10:0] COB_RPDO1 = RPDO1_COB_BASE + 11'(NODE_ID);
    localparam logic [10:0] COB_RPDO2 = RPDO2_COB_BASE + 11'(NODE_ID);
    localparam logic [31:0] COB_RPDO4 = 32'(RPDO4_COB_BASE + 11'(NODE_ID));

    function automatic logic tt_is_sync(input logic [7:0] tt);
        return tt >= TT_SYNC_MIN && tt <= TT_SYNC_MAX;
    endfunction

    function automatic logic tt_is_async(input logic [7:0] tt);
        return tt == TT_ASYNC_A || tt == TT_ASYNC_B;
    endfunction

    logic [7:0] map1_cnt_q, map1_cnt_d, map2_cnt_q, map2_cnt_d;
    logic [31:0] r4_cob_q, r4_cob_d;
    logic [7:0] r4_tt_q, r4_tt_d;
    logic od_pend_q, od_pend_d, od_ack_q, od_ack_d, od_err_q, od_err_d;
    logic od_perr_q, od_perr_d;
    crpm_od_sel_t od_sel_q, od_sel_d, od_dec;
    logic [31:0] od_rdata_q, od_rdata_d;
    logic od_take, mem_we;
    logic [3:0] mem_waddr, mem_raddr;
    logic [31:0] mem_rdata;

    crpm_eng_t eng_q, eng_d;
    logic tbl_q, tbl_d;
    logic [3:0] idx_q, idx_d;
    logic [10:0] off_q, off_d;
    crpm_frame_t frame_q, frame_d;
    logic [15:0] pcw_q, pcw_d;
    logic pcw_v_q, pcw_v_d;
    logic [7:0] pmode_q, pmode_d;
    logic pmode_v_q, pmode_v_d;
    logic [7:0] cnt_sel;
    logic [63:0] shifted;
    crpm_desc_t desc;
    logic rx_take, hit1, hit2, hit4, commit;

    logic [15:0] cw_q, cw_d;
    logic cw_stb_q, cw_stb_d, mode_stb_q, mode_stb_d, vel_stb_q, vel_stb_d;
    logic [7:0] mode_q, mode_d;
    logic [31:0] vel_q, vel_d;
    logic pv_q, pv_d, r4_pend_q, r4_pend_d;
    logic [47:0] r4_data_q, r4_data_d;
    logic [7:0] sync_cnt_q, sync_cnt_d;
    logic r4_apply;
    logic [47:0] r4_apply_data;

    // Frames take priority over the object dictionary port so that a
    // busy configuration tool cannot starve the drive of commands.
    assign rx_ready_o = eng_q == ENG_IDLE && !od_pend_q;
    assign rx_take = rx_valid_i && rx_ready_o;
    assign od_ready_o = eng_q == ENG_IDLE && !od_pend_q && !rx_valid_i;
    assign od_take = od_req_i && od_ready_o;
    assign od_dec = crpm_od_decode(od_index_i, od_sub_i);

    assign hit1 = rx_frame_i.rpdo4_frame_identifier == COB_RPDO1;
    assign hit2 = rx_frame_i.rpdo4_frame_identifier == COB_RPDO2;
    assign hit4 = rx_frame_i.rpdo4_frame_identifier == r4_cob_q[10:0]
        && !r4_cob_q[COB_INVALID_BIT];

    assign mem_we = od_take && od_wr_i && od_dec.kind == OD_MAP_DESC
        && nmt_state_i == NMT_PREOP;
    assign mem_waddr = {od_dec.tbl, od_dec.slot};
    assign mem_raddr = (eng_q == ENG_READ) ? {tbl_q, idx_q[2:0]}
        : {od_dec.tbl, od_dec.slot};

    crpm_desc_mem u_desc_mem (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_waddr),
        .wr_data_i(od_wdata_i),
        .rd_addr_i(mem_raddr),
        .rd_data_o(mem_rdata)
    );

    always_comb
    begin
        map1_cnt_d = map1_cnt_q;
        map2_cnt_d = map2_cnt_q;
        r4_cob_d = r4_cob_q;
        r4_tt_d = r4_tt_q;
        od_pend_d = od_take;
        od_sel_d = od_take ? od_dec : od_sel_q;
        od_perr_d = od_perr_q;
        od_ack_d = od_pend_q;
        od_err_d = od_pend_q ? od_perr_q : 1'b0;
        od_rdata_d = od_rdata_q;
        if (od_take)
        begin
            od_perr_d = od_dec.kind == OD_NONE;
            if (od_wr_i && nmt_state_i != NMT_PREOP)
                od_perr_d = 1'b1;
            else if (od_wr_i)
            begin
                unique case (od_dec.kind)
                    OD_R4_CNT: od_perr_d = 1'b1;
                    OD_R4_COB: r4_cob_d = od_wdata_i;
                    OD_R4_TT: r4_tt_d = od_wdata_i[7:0];
                    OD_MAP_CNT:
                    begin
                        // A count above the table size is refused whole.
                        if (od_wdata_i > 32'(MAP_MAX))
                            od_perr_d = 1'b1;
                        else if (od_dec.tbl)
                            map2_cnt_d = od_wdata_i[7:0];
                        else
                            map1_cnt_d = od_wdata_i[7:0];
                    end
                    OD_MAP_DESC, OD_NONE: ;
                endcase
            end
        end
        if (od_pend_q)
        begin
            unique case (od_sel_q.kind)
                OD_R4_CNT: od_rdata_d = 32'(R4_COMM_ENTRIES);
                OD_R4_COB: od_rdata_d = r4_cob_q;
                OD_R4_TT: od_rdata_d = 32'(r4_tt_q);
                OD_MAP_CNT: od_rdata_d = 32'(od_sel_q.tbl ? map2_cnt_q
                    : map1_cnt_q);
                OD_MAP_DESC: od_rdata_d = mem_rdata;
                OD_NONE: od_rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            map1_cnt_q <= MAP1_CNT_RST;
            map2_cnt_q <= MAP2_CNT_RST;
            r4_cob_q <= COB_RPDO4;
            r4_tt_q <= TT_RST;
            od_pend_q <= 1'b0;
            od_sel_q <= '{kind: OD_NONE, tbl: 1'b0, slot: 3'h0};
            od_perr_q <= 1'b0;
            od_ack_q <= 1'b0;
            od_err_q <= 1'b0;
            od_rdata_q <= 32'h00000000;
        end
        else
        begin
            map1_cnt_q <= map1_cnt_d;
            map2_cnt_q <= map2_cnt_d;
            r4_cob_q <= r4_cob_d;
            r4_tt_q <= r4_tt_d;
            od_pend_q <= od_pend_d;
            od_sel_q <= od_sel_d;
            od_perr_q <= od_perr_d;
            od_ack_q <= od_ack_d;
            od_err_q <= od_err_d;
            od_rdata_q <= od_rdata_d;
        end
    end

    assign cnt_sel = tbl_q ? map2_cnt_q : map1_cnt_q;
    assign desc = crpm_desc_t'(mem_rdata);
    assign shifted = frame_q.data >> off_q;
    assign commit = eng_q == ENG_DONE && off_q <= FRAME_BITS
        && off_q <= {4'h0, frame_q.dlc, 3'h0};

    always_comb
    begin
        eng_d = eng_q;
        tbl_d = tbl_q;
        idx_d = idx_q;
        off_d = off_q;
        frame_d = frame_q;
        pcw_d = pcw_q;
        pcw_v_d = pcw_v_q;
        pmode_d = pmode_q;
        pmode_v_d = pmode_v_q;
        unique case (eng_q)
            ENG_IDLE:
            begin
                if (rx_take && nmt_state_i == NMT_OPER
                    && (hit1 || hit2))
                begin
                    eng_d = ENG_READ;
                    tbl_d = hit2;
                    idx_d = 4'h0;
                    off_d = 11'h000;
                    frame_d = rx_frame_i;
                    pcw_v_d = 1'b0;
                    pmode_v_d = 1'b0;
                end
            end
            ENG_READ:
            begin
                if (idx_q >= cnt_sel[3:0])
                    eng_d = ENG_DONE;
                else
                    eng_d = ENG_EVAL;
            end
            ENG_EVAL:
            begin
                if (desc.index == OBJ_CTRL_WORD && desc.sub == OBJ_SUB
                    && desc.len == LEN_CTRL_WORD)
                begin
                    pcw_d = shifted[15:0];
                    pcw_v_d = 1'b1;
                end
                if (desc.index == OBJ_OP_MODE && desc.sub == OBJ_SUB
                    && desc.len == LEN_OP_MODE)
                begin
                    pmode_d = shifted[7:0];
                    pmode_v_d = 1'b1;
                end
                off_d = off_q + 11'(desc.len);
                idx_d = idx_q + 4'h1;
                eng_d = ENG_READ;
            end
            ENG_DONE: eng_d = ENG_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            eng_q <= ENG_IDLE;
            tbl_q <= 1'b0;
            idx_q <= 4'h0;
            off_q <= 11'h000;
            frame_q <= '0;
            pcw_q <= 16'h0000;
            pcw_v_q <= 1'b0;
            pmode_q <= 8'h00;
            pmode_v_q <= 1'b0;
        end
        else
        begin
            eng_q <= eng_d;
            tbl_q <= tbl_d;
            idx_q <= idx_d;
            off_q <= off_d;
            frame_q <= frame_d;
            pcw_q <= pcw_d;
            pcw_v_q <= pcw_v_d;
            pmode_q <= pmode_d;
            pmode_v_q <= pmode_v_d;
        end
    end

    // The velocity PDO has a fixed layout, so it bypasses the walk.
    always_comb
    begin
        r4_pend_d = r4_pend_q;
        r4_data_d = r4_data_q;
        sync_cnt_d = sync_cnt_q;
        r4_apply = 1'b0;
        r4_apply_data = r4_data_q;
        if (nmt_state_i != NMT_OPER)
            r4_pend_d = 1'b0;
        else if (rx_take && hit4 && rx_frame_i.dlc >= R4_MIN_BYTES)
        begin
            if (tt_is_async(r4_tt_q))
            begin
                r4_apply = 1'b1;
                r4_apply_data = rx_frame_i.data[47:0];
            end
            else if (tt_is_sync(r4_tt_q))
            begin
                r4_pend_d = 1'b1;
                r4_data_d = rx_frame_i.data[47:0];
            end
        end
        if (sync_i && tt_is_sync(r4_tt_q))
        begin
            if (sync_cnt_q + 8'h01 >= r4_tt_q)
            begin
                sync_cnt_d = 8'h00;
                // Data arriving with the n-th SYNC waits for the next round.
                if (r4_pend_q && nmt_state_i == NMT_OPER)
                begin
                    r4_apply = 1'b1;
                    r4_apply_data = r4_data_q;
                    r4_pend_d = r4_pend_d && !(r4_data_d == r4_data_q
                        && !(rx_take && hit4));
                end
            end
            else
                sync_cnt_d = sync_cnt_q + 8'h01;
        end
        cw_d = cw_q;
        mode_d = mode_q;
        vel_d = vel_q;
        pv_d = pv_q;
        cw_stb_d = 1'b0;
        mode_stb_d = 1'b0;
        vel_stb_d = 1'b0;
        if (commit && pcw_v_q)
        begin
            cw_d = pcw_q;
            cw_stb_d = 1'b1;
        end
        if (commit && pmode_v_q)
        begin
            mode_d = pmode_q;
            mode_stb_d = 1'b1;
        end
        if (r4_apply)
        begin
            cw_d = r4_apply_data[R4_CW_LSB +: 16];
            vel_d = r4_apply_data[R4_VEL_LSB +: 32];
            cw_stb_d = 1'b1;
            vel_stb_d = 1'b1;
            pv_d = 1'b1;
        end
        else if (mode_stb_d)
            pv_d = 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            r4_pend_q <= 1'b0;
            r4_data_q <= 48'h000000000000;
            sync_cnt_q <= 8'h00;
            cw_q <= 16'h0000;
            cw_stb_q <= 1'b0;
            mode_q <= 8'h00;
            mode_stb_q <= 1'b0;
            vel_q <= 32'h00000000;
            vel_stb_q <= 1'b0;
            pv_q <= 1'b0;
        end
        else
        begin
            r4_pend_q <= r4_pend_d;
            r4_data_q <= r4_data_d;
            sync_cnt_q <= sync_cnt_d;
            cw_q <= cw_d;
            cw_stb_q <= cw_stb_d;
            mode_q <= mode_d;
            mode_stb_q <= mode_stb_d;
            vel_q <= vel_d;
            vel_stb_q <= vel_stb_d;
            pv_q <= pv_d;
        end
    end

    assign od_ack_o = od_ack_q;
    assign od_err_o = od_err_q;
    assign od_rdata_o = od_rdata_q;
    assign ctrl_word_o = cw_q;
    assign ctrl_word_stb_o = cw_stb_q;
    assign op_mode_o = mode_q;
    assign op_mode_stb_o = mode_stb_q;
    assign target_velocity_o = vel_q;
    assign target_velocity_stb_o = vel_stb_q;
    assign velocity_profile_setpoint_mode_o = pv_q;

endmodule // crpm_rx_map
